//--- core/seq_pkg.sv
// What this block does
// - segment starts only on enable's valid edge
// - new selection ignored during run, accepted after
// - select bits binary, segment number is the value itself
// - no dwell inserted between segments
// - positioning complete asserted after each segment
// - enable off mid-segment: finish segment anyway
// - selection changes ignored until segment done
// - same selection reruns the same segment
// - enable edge after completion runs new segment
// - servo off: stop, complete stays low
// - direction input frozen for whole segment
package seq_pkg;
	// clock and minimum enable pulse widths
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLOW_PULSE_NS = 3000000; // 3 ms
	localparam int FAST_PULSE_NS = 250000; // 0.25 ms
	// least times round up to whole cycles
	localparam int SLOW_PULSE_CYCLES = (SLOW_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_PULSE_CYCLES = (FAST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WIDTH_CNT_W = 20;
	// segment table geometry
	localparam int SEG_COUNT = 16;
	localparam int SEG_BITS = 4;
	localparam int DISP_W = 32;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] REMAIN_OFFSET = 8'h08;
	localparam logic [1:0] SEG_BASE_HI = 2'h1; // table at 0x40..0x7c
	// control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_RUNPOL_BIT = 1;
	localparam int CTRL_SELPOL_LSB = 2;
	localparam int CTRL_DIRPOL_BIT = 6;
	localparam int CTRL_FAST_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_STOP_BIT = 2;
	localparam int STAT_SEG_LSB = 4;
	localparam int STAT_DIR_BIT = 8;
	localparam int STAT_SHORT_BIT = 9;
	// sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_HALT} seq_state_t;
endpackage

//--- core/seg_mem_if.sv
// segment displacement table ports: one bus write/read side, one sequencer read
interface seg_mem_if;
	logic wEn; // bus write strobe
	logic [3:0] wAddr; // written segment index
	logic [31:0] wData; // written displacement
	logic [3:0] busAddr; // bus read index
	logic [31:0] busData; // registered bus read data
	logic [3:0] seqAddr; // sequencer read index
	logic [31:0] seqData; // registered sequencer read data
	modport user(output wEn, wAddr, wData, busAddr, seqAddr, input busData, seqData);
	modport mem(input wEn, wAddr, wData, busAddr, seqAddr, output busData, seqData);
endinterface

//--- core/seg_table_mem.sv
module seg_table_mem (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	seg_mem_if.mem port
);
	// displacement store, no reset: software loads it before use
	logic [seq_pkg::DISP_W-1:0] table_q [seq_pkg::SEG_COUNT];

	// write port
	always_ff @(posedge core_clk) begin
		if (ce && port.wEn) begin
			table_q[port.wAddr] <= port.wData;
		end
	end

	// two registered read ports so bus reads never stall a segment start
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port.busData <= 32'h0;
			port.seqData <= 32'h0;
		end else if (ce) begin
			port.busData <= table_q[port.busAddr];
			port.seqData <= table_q[port.seqAddr];
		end
	end
endmodule

//--- core/di_switched_segment_sequencer.sv
module di_switched_segment_sequencer #(
	parameter int SLOW_MIN_CYCLES = seq_pkg::SLOW_PULSE_CYCLES, // shorten in simulation
	parameter int FAST_MIN_CYCLES = seq_pkg::FAST_PULSE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] segment_select,
	input wire logic segment_run_enable,
	input wire logic direction_select_input,
	input wire logic servoEnable,
	input wire logic stopDone,
	output logic stepPulse,
	output logic stepDir,
	output logic positionComplete,
	output logic servoOffStop
);
	// software control and sticky flags
	logic [7:0] ctrl;
	logic shortPulse; // enable pulse narrower than the minimum
	// pin synchronisers: stage A feeds stage B only
	logic [6:0] pinSyncA;
	logic [6:0] pinSyncB;
	// sequencer state
	seq_pkg::seq_state_t state;
	logic runValidPrev;
	logic [3:0] latchedSeg;
	logic latchedDir;
	logic moveDir;
	logic [31:0] remain;
	logic [seq_pkg::WIDTH_CNT_W-1:0] widthCnt;
	// bus access phase second cycle marker
	logic rdyFlag;

	seg_mem_if memBus();

	// magnitude of a signed displacement
	function automatic logic [31:0] absDisp(input logic [31:0] d);
		absDisp = d[31] ? (~d + 32'h1) : d;
	endfunction

	// select register for a bus address
	function automatic logic hitReg(input logic [7:0] a, input logic [7:0] off);
		hitReg = (a == off);
	endfunction

	seg_table_mem u_table (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ce(ce),
		.port(memBus.mem)
	);

	// two flops on every pin except stopDone before any logic sees it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pinSyncA <= 7'h00;
			pinSyncB <= 7'h00;
		end else if (ce) begin
			pinSyncA <= {servoEnable, direction_select_input, segment_run_enable, segment_select};
			pinSyncB <= pinSyncA;
		end
	end

	// polarity-corrected levels; servo enable used as is
	wire [3:0] selValid = pinSyncB[3:0] ^ ctrl[seq_pkg::CTRL_SELPOL_LSB +: 4];
	wire runValid = pinSyncB[4] ^ ctrl[seq_pkg::CTRL_RUNPOL_BIT];
	wire dirValid = pinSyncB[5] ^ ctrl[seq_pkg::CTRL_DIRPOL_BIT];
	wire servoOn = pinSyncB[6];
	wire modeOn = ctrl[seq_pkg::CTRL_ENABLE_BIT];
	// only the inactive-to-valid transition counts, never the held level
	wire runEdge = runValid & ~runValidPrev;
	wire runFall = ~runValid & runValidPrev;
	// edges while busy are dropped: the selection is frozen until done
	wire startReq = (state == seq_pkg::ST_IDLE) && runEdge && modeOn && servoOn;
	wire segDone = (state == seq_pkg::ST_RUN) && servoOn && (remain == 32'h0);
	wire stepNow = (state == seq_pkg::ST_RUN) && servoOn && (remain != 32'h0);
	// chosen minimum width for the enable input type in use
	wire [seq_pkg::WIDTH_CNT_W-1:0] minWidth = ctrl[seq_pkg::CTRL_FAST_BIT] ?
		FAST_MIN_CYCLES[seq_pkg::WIDTH_CNT_W-1:0] : SLOW_MIN_CYCLES[seq_pkg::WIDTH_CNT_W-1:0];

	// sequencer reads the live selection so data is ready the cycle after the edge
	assign memBus.seqAddr = selValid;

	// enable edge history
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			runValidPrev <= 1'b0;
		end else if (ce) begin
			runValidPrev <= runValid;
		end
	end

	// segment sequencing
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= seq_pkg::ST_IDLE;
			latchedSeg <= 4'h0;
			latchedDir <= 1'b0;
			moveDir <= 1'b0;
			remain <= 32'h0;
		end else if (ce) begin
			case (state)
				seq_pkg::ST_IDLE: begin
					// capture selection and direction once, at the edge
					if (startReq) begin
						latchedSeg <= selValid;
						latchedDir <= dirValid;
						state <= seq_pkg::ST_LOAD;
					end
				end
				seq_pkg::ST_LOAD: begin
					// table data arrives now; start at once, no dwell
					if (!servoOn) begin
						state <= seq_pkg::ST_HALT;
					end else begin
						remain <= absDisp(memBus.seqData);
						moveDir <= memBus.seqData[31] ^ latchedDir;
						state <= seq_pkg::ST_RUN;
					end
				end
				seq_pkg::ST_RUN: begin
					// enable level is not looked at here: the segment runs out unless the servo goes off
					if (!servoOn) begin
						state <= seq_pkg::ST_HALT;
					end else if (remain == 32'h0) begin
						state <= seq_pkg::ST_IDLE;
					end else begin
						remain <= remain - 32'h1;
					end
				end
				seq_pkg::ST_HALT: begin
					// wait for the servo-off stop to finish, leftover is discarded
					if (stopDone) begin
						remain <= 32'h0;
						state <= seq_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// command outputs, all registered
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stepPulse <= 1'b0;
			stepDir <= 1'b0;
			positionComplete <= 1'b0;
			servoOffStop <= 1'b0;
		end else if (ce) begin
			stepPulse <= stepNow;
			stepDir <= moveDir;
			servoOffStop <= (state == seq_pkg::ST_HALT && !stopDone) ||
				(state != seq_pkg::ST_IDLE && state != seq_pkg::ST_HALT && !servoOn);
			// completion held until the next start or a servo-off
			if (startReq || !servoOn) begin
				positionComplete <= 1'b0;
			end else if (segDone) begin
				positionComplete <= 1'b1;
			end
		end
	end

	// enable width check: flags pulses shorter than the input type's minimum
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			widthCnt <= '0;
		end else if (ce) begin
			if (!runValid) begin
				widthCnt <= '0;
			end else if (widthCnt != {seq_pkg::WIDTH_CNT_W{1'b1}}) begin
				widthCnt <= widthCnt + 1'b1;
			end
		end
	end

	// bus decode
	wire hitCtrl = hitReg(paddr, seq_pkg::CTRL_OFFSET);
	wire hitStatus = hitReg(paddr, seq_pkg::STATUS_OFFSET);
	wire hitRemain = hitReg(paddr, seq_pkg::REMAIN_OFFSET);
	wire hitSeg = (paddr[7:6] == seq_pkg::SEG_BASE_HI) && (paddr[1:0] == 2'h0);
	wire mapped = hitCtrl | hitStatus | hitRemain | hitSeg;
	wire accessEnd = psel && penable && pready;
	wire wrEnd = accessEnd && pwrite && mapped;
	// status word built from live state
	wire [31:0] statusWord = {22'h0, shortPulse, latchedDir, latchedSeg, 1'b0,
		(state == seq_pkg::ST_HALT), positionComplete, (state != seq_pkg::ST_IDLE)};
	wire [31:0] readMux = hitCtrl ? {24'h0, ctrl} :
		hitStatus ? statusWord :
		hitRemain ? remain :
		hitSeg ? memBus.busData : 32'h0;

	// a set in the same cycle as a write-one clear wins
	wire shortSet = runFall && (widthCnt < minWidth);
	wire shortClr = wrEnd && hitStatus && pwdata[seq_pkg::STAT_SHORT_BIT];

	// table write and bus-side read index
	assign memBus.wEn = wrEnd && hitSeg;
	assign memBus.wAddr = paddr[5:2];
	assign memBus.wData = pwdata;
	assign memBus.busAddr = paddr[5:2];
	// two-cycle access phase: first cycle loads prdata, second answers
	assign pready = rdyFlag && ce;
	assign pslverr = pready && !mapped;

	// bus access timing and read data
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdyFlag <= 1'b0;
			prdata <= 32'h0;
		end else if (ce) begin
			rdyFlag <= psel && penable && !rdyFlag;
			if (psel && penable && !rdyFlag) begin
				prdata <= pwrite ? 32'h0 : readMux;
			end
		end
	end

	// control register and sticky flag
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= seq_pkg::CTRL_RESET;
			shortPulse <= 1'b0;
		end else if (ce) begin
			if (wrEnd && hitCtrl) begin
				ctrl <= pwdata[7:0];
			end
			if (shortSet) begin
				shortPulse <= 1'b1;
			end else if (shortClr) begin
				shortPulse <= 1'b0;
			end
		end
	end

	// checks, all under the one clock and reset
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	property p_edge_only;
		(state == seq_pkg::ST_IDLE && ce && !runEdge) |=> (state == seq_pkg::ST_IDLE);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("segment began without edge");

	property p_busy_ignores;
		(state == seq_pkg::ST_RUN && ce && runEdge) |=> (state != seq_pkg::ST_LOAD);
	endproperty
	a_busy_ignores: assert property (p_busy_ignores) else $error("edge restarted busy segment");

	property p_select_value;
		(startReq && ce) |=> (latchedSeg == $past(selValid)) && (state == seq_pkg::ST_LOAD);
	endproperty
	a_select_value: assert property (p_select_value) else $error("wrong segment latched");

	property p_no_dwell;
		(startReq && ce) ##1 (ce && servoOn) |=> (state == seq_pkg::ST_RUN);
	endproperty
	a_no_dwell: assert property (p_no_dwell) else $error("dwell inserted before segment");

	property p_complete;
		(segDone && ce) |=> positionComplete && (state == seq_pkg::ST_IDLE);
	endproperty
	a_complete: assert property (p_complete) else $error("no completion after segment");

	property p_enable_off_runs;
		(stepNow && ce && !runValid) |=> (remain == $past(remain) - 32'h1) && stepPulse;
	endproperty
	a_enable_off_runs: assert property (p_enable_off_runs) else $error("segment cut short");

	property p_select_frozen;
		(state != seq_pkg::ST_IDLE && ce) |=> (latchedSeg == $past(latchedSeg));
	endproperty
	a_select_frozen: assert property (p_select_frozen) else $error("selection moved mid-segment");

	property p_servo_off;
		(state == seq_pkg::ST_RUN && ce && !servoOn) |=>
			(state == seq_pkg::ST_HALT) && !positionComplete && servoOffStop;
	endproperty
	a_servo_off: assert property (p_servo_off) else $error("servo off not handled");

	property p_dir_fixed;
		(state == seq_pkg::ST_RUN && ce) |=> (moveDir == $past(moveDir));
	endproperty
	a_dir_fixed: assert property (p_dir_fixed) else $error("direction changed mid-segment");

	c_segment_done: cover property (segDone && ce);
	c_servo_stop: cover property (state == seq_pkg::ST_HALT && stopDone && ce);
	c_repeat_seg: cover property ((segDone && ce) ##[1:200] (startReq && selValid == latchedSeg));
endmodule

//--- test/pin_driver.sv
// behavioural controller on the far side: drives the digital inputs
module pin_driver (
	input wire logic core_clk,
	input wire logic positionComplete,
	input wire logic servoOffStop,
	output logic [3:0] segment_select,
	output logic segment_run_enable,
	output logic direction_select_input,
	output logic servoEnable,
	output logic stopDone
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] selPol = 4'h0; // pin level that means a select bit of 0
	logic runPol = 1'b0; // pin level that means enable inactive
	int stopDelay = 1; // cycles the stop takes, raised for a slow answer
	int stopCnt = 0;
	int holdCycles = 17; // enable cycles after the mid-pulse point, lowered for a narrow pulse
	initial begin
		segment_select = 4'h0;
		segment_run_enable = 1'b0;
		direction_select_input = 1'b0;
		servoEnable = 1'b1;
		stopDone = 1'b0;
	end
	// the stop finishes stopDelay cycles after it began, held until released
	always @(posedge core_clk) begin
		stopCnt <= servoOffStop ? stopCnt + 1 : 0;
		stopDone <= servoOffStop && stopCnt >= stopDelay;
	end
	// change pin polarity; enable goes to its new idle level at once
	task setPol(input logic [3:0] s, input logic r);
		@(posedge core_clk);
		selPol = s;
		runPol = r;
		segment_run_enable <= r;
	endtask
	// one segment: select first, then a valid enable pulse of 8 + holdCycles cycles
	task automatic runSeg(input logic [3:0] sel, input bit swap, input bit kill, output bit ok);
		int n;
		@(posedge core_clk);
		segment_select <= sel ^ selPol;
		repeat (3) @(posedge core_clk);
		segment_run_enable <= ~runPol;
		repeat (8) @(posedge core_clk);
		// a misbehaving controller: select and direction move mid-segment
		if (swap) begin
			segment_select <= ~sel ^ selPol;
			direction_select_input <= ~direction_select_input;
		end
		if (kill) begin
			servoEnable <= 1'b0;
		end
		// by default 25 cycles in all, longer than the shortened minimum of 20
		repeat (holdCycles) @(posedge core_clk);
		segment_run_enable <= runPol;
		ok = 1'b0;
		for (n = 0; n < 400 && !ok; n++) begin
			@(posedge core_clk);
			ok = kill ? !servoOffStop : positionComplete;
		end
		servoEnable <= 1'b1;
	endtask
endmodule

//--- test/tb.sv
// self-checking bench: step counts per segment are noted, then compared
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1; // never frozen here
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] segment_select;
	logic segment_run_enable;
	logic direction_select_input;
	logic servoEnable;
	logic stopDone;
	logic stepPulse;
	logic stepDir;
	logic positionComplete;
	logic servoOffStop;
	logic [31:0] rs = 32'h00015060; // xorshift state
	logic [31:0] rd;
	logic er;
	logic dir0; // direction at the first step of a segment
	logic expDir; // direction the next segment must run in
	logic dirInv = 1'b0; // direction input read inverted
	logic prevDone = 1'b0;
	logic prevStop = 1'b0;
	int q[$]; // expected steps, -1 for a servo-off stop
	int disp[16];
	int cnt = 0;
	int miscompares = 0;
	int total_checks = 0;
	always #2 core_clk = ~core_clk;
	di_switched_segment_sequencer #(.SLOW_MIN_CYCLES(20), .FAST_MIN_CYCLES(5))
		di_switched_segment_sequencer_i (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .segment_select(segment_select),
		.segment_run_enable(segment_run_enable), .direction_select_input(direction_select_input),
		.servoEnable(servoEnable), .stopDone(stopDone), .stepPulse(stepPulse), .stepDir(stepDir),
		.positionComplete(positionComplete), .servoOffStop(servoOffStop));
	pin_driver pin_driver_i (.core_clk(core_clk), .positionComplete(positionComplete),
		.servoOffStop(servoOffStop), .segment_select(segment_select),
		.segment_run_enable(segment_run_enable), .direction_select_input(direction_select_input),
		.servoEnable(servoEnable), .stopDone(stopDone));
	function logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		check(q.size(), 0);
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			miscompares++;
			results();
		end
	endtask
	// note the expected outcome, let the controller run it, read status
	task automatic seg(input logic [3:0] s, input bit sw, input bit k);
		bit ok;
		q.push_back(k ? -1 : (disp[s] < 0 ? -disp[s] : disp[s]));
		// displacement sign flipped by the valid level of the direction input
		expDir = (disp[s] < 0) ^ pin_driver_i.direction_select_input ^ dirInv;
		pin_driver_i.runSeg(s, sw, k, ok);
		check(ok, 1'b1);
		if (!ok) results();
		if (k) begin
			check(positionComplete, 1'b0);
		end else begin
			apb(seq_pkg::STATUS_OFFSET, 1'b0, 32'h0);
			check(rd[7:4], s);
			check(rd[1], 1'b1);
		end
	endtask
	// watcher: counts steps, compares at each completion or stop
	always @(posedge core_clk) begin
		if (stepPulse === 1'b1) begin
			if (cnt == 0) begin
				dir0 = stepDir;
				check(stepDir, expDir);
			end else begin
				check(stepDir, dir0);
			end
			cnt++;
		end
		if (positionComplete === 1'b1 && prevDone !== 1'b1) begin
			check(cnt, q.size() > 0 ? q.pop_front() : -2);
			cnt = 0;
		end
		if (servoOffStop === 1'b1 && prevStop !== 1'b1) begin
			check(-1, q.size() > 0 ? q.pop_front() : -2);
			cnt = 0;
		end
		prevDone = positionComplete;
		prevStop = servoOffStop;
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		apb(seq_pkg::CTRL_OFFSET, 1'b0, 32'h0);
		check(rd, 32'h0);
		apb(8'h20, 1'b0, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		// short random moves, one long move at index 5
		for (int i = 0; i < 16; i++) begin
			rs = rnd();
			disp[i] = (rs[31] ? -1 : 1) * (1 + int'(rs[2:0]));
			if (i == 5) disp[i] = -40;
			apb(8'h40 + 8'(4 * i), 1'b1, 32'(disp[i]));
		end
		apb(8'h54, 1'b0, 32'h0);
		check(rd, 32'(disp[5]));
		apb(seq_pkg::CTRL_OFFSET, 1'b1, 32'h1);
		for (int v = 0; v < 16; v++) seg(4'(v), 1'b0, 1'b0);
		seg(4'hf, 1'b0, 1'b0);
		seg(4'h5, 1'b1, 1'b0);
		seg(4'h5, 1'b0, 1'b1);
		pin_driver_i.stopDelay = 30;
		seg(4'h5, 1'b0, 1'b1);
		seg(4'h5, 1'b0, 1'b0);
		// inverted pins: mode off while the levels move
		apb(seq_pkg::CTRL_OFFSET, 1'b1, 32'h0);
		pin_driver_i.setPol(4'hf, 1'b1);
		dirInv = 1'b1;
		apb(seq_pkg::CTRL_OFFSET, 1'b1, 32'h7f);
		seg(4'h0, 1'b0, 1'b0);
		seg(4'h9, 1'b0, 1'b0);
		// the polarity swap leaves a stray narrow-pulse flag: clear it first
		apb(seq_pkg::STATUS_OFFSET, 1'b1, 32'h1 << seq_pkg::STAT_SHORT_BIT);
		// fast input: a 25-cycle pulse is wide enough
		apb(seq_pkg::CTRL_OFFSET, 1'b1, 32'hff);
		seg(4'h3, 1'b0, 1'b0);
		check(rd[seq_pkg::STAT_SHORT_BIT], 1'b0);
		// ordinary input again, 10-cycle pulse: flagged, segment still runs
		apb(seq_pkg::CTRL_OFFSET, 1'b1, 32'h7f);
		pin_driver_i.holdCycles = 2;
		seg(4'h3, 1'b0, 1'b0);
		check(rd[seq_pkg::STAT_SHORT_BIT], 1'b1);
		apb(seq_pkg::STATUS_OFFSET, 1'b1, 32'h1 << seq_pkg::STAT_SHORT_BIT);
		apb(seq_pkg::STATUS_OFFSET, 1'b0, 32'h0);
		check(rd[seq_pkg::STAT_SHORT_BIT], 1'b0);
		results();
	end
endmodule
